// ### hdl/podec_pkg.sv
/*
 * Constants, field layouts and carrier types for the positioning option
 * decoder. Assumes a single 250 MHz device clock and an object port that
 * addresses registers by their object index.
 */
// How it works
// (RULE1) 16-bit option word, resets to 0001h
// (RULE2) Bits 1..0 pick relative reference, ctrl bit6
// (RULE3) Code 00: add to previous target, else 0
// (RULE4) Code 01: relative to ramp generator output
// (RULE5) Code 10: relative to actual position
// (RULE6) Release new setpoint, then clear acknowledge
// (RULE7) Held controlword updated on internal release
// (RULE8) Code 00 host handshake; 01 release at target
// (RULE9) Code 10 release at once; 11 reserved
// (RULE10) Direction 00: linear, wrap at range limits
// (RULE11) Direction 01: negative only, via minimum
// (RULE12) Direction 10: positive only, via maximum
// (RULE13) Direction 11: shortest path, half-range test
// (RULE14) Signed 32-bit following error, resets zero
// (RULE15) Input word: lower, upper, reference switches
// (RULE16) General inputs one to eight in 23..16
// (RULE17) Unsupported bits ignored, reserved codes inert; code stores all 16 option bits unmasked
package podec_pkg;

    localparam logic [15:0] PODEC_IDX_OPTIONS  = 16'h60f2;
    localparam logic [15:0] PODEC_IDX_FOLLOW   = 16'h60f4;
    localparam logic [15:0] PODEC_IDX_INPUTS   = 16'h60fd;
    localparam logic [15:0] PODEC_OPT_RESET    = 16'h0001;
    localparam logic [15:0] PODEC_OPT_MASK     = 16'h00f3;

    localparam int PODEC_REL_LSB  = 0;
    localparam int PODEC_RLS_LSB  = 4;
    localparam int PODEC_DIR_LSB  = 6;
    localparam int PODEC_CW_NEWSP = 4;
    localparam int PODEC_CW_REL   = 6;
    localparam int PODEC_SW_ACK   = 12;
    localparam int PODEC_DI_LOWER = 0;
    localparam int PODEC_DI_UPPER = 1;
    localparam int PODEC_DI_REF   = 2;
    localparam int PODEC_DI_GP    = 16;
    localparam int PODEC_GP_NUM   = 8;

    typedef enum logic [1:0] {
        PODEC_REL_PREV   = 2'b00,
        PODEC_REL_RAMP   = 2'b01,
        PODEC_REL_ACTUAL = 2'b10,
        PODEC_REL_RSVD   = 2'b11
    } podec_rel_t;

    typedef enum logic [1:0] {
        PODEC_RLS_HOST   = 2'b00,
        PODEC_RLS_TARGET = 2'b01,
        PODEC_RLS_ASAP   = 2'b10,
        PODEC_RLS_RSVD   = 2'b11
    } podec_rls_t;

    typedef enum logic [1:0] {
        PODEC_DIR_LINEAR   = 2'b00,
        PODEC_DIR_NEGATIVE = 2'b01,
        PODEC_DIR_POSITIVE = 2'b10,
        PODEC_DIR_SHORTEST = 2'b11
    } podec_dir_t;

    typedef enum logic [1:0] {
        PODEC_SHK_IDLE = 2'b00,
        PODEC_SHK_WAIT = 2'b01,
        PODEC_SHK_ACK  = 2'b10
    } podec_shk_t;

    // Object port request from the process data engine
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] index;
        logic [31:0] wdata;
    } podec_obj_req_t;

    // Move request from the profile generator side
    typedef struct packed {
        logic        valid;
        logic signed [31:0] target;
        logic signed [31:0] ramp_pos;
        logic signed [31:0] actual_pos;
        logic signed [31:0] range_min;
        logic signed [31:0] range_max;
    } podec_move_req_t;

    // Resolved move for the trajectory generator
    typedef struct packed {
        logic        valid;
        logic        dir_positive;
        logic        via_limit;
        logic signed [31:0] target;
    } podec_move_t;

endpackage

// ### hdl/podec_top.sv
/*
 * Positioning option decoder: holds the option word, resolves relative
 * targets and rotary direction, auto-releases the new-setpoint bit, and
 * exposes the following error and digital input words over an object port.
 * Assumes the object port and move requests come from logic on clk_sys_i;
 * switch and general inputs are pins and are synchronised here.
 */
`timescale 1ns/1ps
module podec_top (
    input  wire logic                      clk_sys_i,    // 250 MHz clock
    input  wire logic                      rst_n_i,      // Sync reset, low
    input  wire podec_pkg::podec_obj_req_t obj_req_i,    // Object access
    output logic [31:0]                    obj_rdata_o,  // Read data
    output logic                           obj_rvalid_o, // Read data valid
    output logic                           obj_err_o,    // Refused access
    input  wire logic                      cw_wr_i,      // Host writes cw
    input  wire logic [15:0]               cw_wdata_i,   // Host cw value
    output logic [15:0]                    cw_o,         // Held controlword
    input  wire logic                      sp_ack_set_i, // Setpoint taken
    output logic                           sp_ack_o,     // Status bit 12
    input  wire logic                      target_reached_i, // Move done
    input  wire podec_pkg::podec_move_req_t move_req_i,  // Move request
    output podec_pkg::podec_move_t         move_o,       // Resolved move
    input  wire logic signed [31:0]        follow_err_i, // Following error
    input  wire logic                      lower_travel_switch_i, // Pin
    input  wire logic                      upper_travel_switch_i, // Pin
    input  wire logic                      reference_switch_i,    // Pin
    input  wire logic [7:0]                gp_in_i       // General inputs
);
    import podec_pkg::*;

    logic [15:0]        opt_q, opt_d;
    logic [15:0]        cw_q, cw_d;
    logic               ack_q, ack_d;
    podec_shk_t         shk_q, shk_d;
    logic signed [31:0] prev_tgt_q, prev_tgt_d;
    podec_move_t        mv_q, mv_d;
    logic signed [31:0] ferr_q, ferr_d;
    logic [31:0]        rdata_q, rdata_d;
    logic               rvalid_q, rvalid_d;
    logic               err_q, err_d;
    logic [10:0]        sync1_q, sync2_q;
    logic [31:0]        din_w;

    podec_rel_t rel_w;
    podec_rls_t rls_w;
    podec_dir_t dir_w;

    // (RULE17) Reserved codes ignored
    assign rel_w = podec_rel_t'(opt_q[PODEC_REL_LSB +: 2]);
    assign rls_w = podec_rls_t'(opt_q[PODEC_RLS_LSB +: 2]);
    assign dir_w = podec_dir_t'(opt_q[PODEC_DIR_LSB +: 2]);

    // Pin synchronisers, two flops each
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= {gp_in_i, reference_switch_i,
                        upper_travel_switch_i, lower_travel_switch_i};
            sync2_q <= sync1_q;
        end
    end

    // (RULE15) Switch bit placement
    always_comb begin
        din_w = '0;
        din_w[PODEC_DI_LOWER] = sync2_q[0];
        din_w[PODEC_DI_UPPER] = sync2_q[1];
        din_w[PODEC_DI_REF]   = sync2_q[2];
        // (RULE16) General inputs field
        din_w[PODEC_DI_GP +: PODEC_GP_NUM] = sync2_q[10:3];
    end

    // Option word, object reads and following error
    always_comb begin
        opt_d    = opt_q;
        rdata_d  = rdata_q;
        rvalid_d = 1'b0;
        err_d    = 1'b0;
        // (RULE14) Following error sampled
        ferr_d   = follow_err_i;
        if (obj_req_i.wr) begin
            if (obj_req_i.index == PODEC_IDX_OPTIONS) begin
                // (RULE1) Option word write
                opt_d = obj_req_i.wdata[15:0];
            end else begin
                err_d = 1'b1;
            end
        end
        if (obj_req_i.rd) begin
            rvalid_d = 1'b1;
            case (obj_req_i.index)
                PODEC_IDX_OPTIONS: rdata_d = {16'h0000, opt_q};
                PODEC_IDX_FOLLOW:  rdata_d = ferr_q;
                PODEC_IDX_INPUTS:  rdata_d = din_w;
                default: begin
                    rdata_d = '0;
                    err_d   = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            opt_q    <= PODEC_OPT_RESET;
            rdata_q  <= '0;
            rvalid_q <= 1'b0;
            err_q    <= 1'b0;
            ferr_q   <= '0;
        end else begin
            opt_q    <= opt_d;
            rdata_q  <= rdata_d;
            rvalid_q <= rvalid_d;
            err_q    <= err_d;
            ferr_q   <= ferr_d;
        end
    end

    // Setpoint handshake and held controlword
    always_comb begin
        cw_d  = cw_q;
        ack_d = ack_q;
        shk_d = shk_q;
        if (cw_wr_i) begin
            cw_d = cw_wdata_i;
        end
        if (sp_ack_set_i) begin
            ack_d = 1'b1;
        end
        case (shk_q)
            PODEC_SHK_IDLE: begin
                // (RULE8) Code 00 leaves host
                if (sp_ack_set_i && (rls_w == PODEC_RLS_TARGET ||
                                     rls_w == PODEC_RLS_ASAP)) begin
                    shk_d = PODEC_SHK_WAIT;
                end
            end
            PODEC_SHK_WAIT: begin
                // (RULE9) Release as soon as possible
                if (rls_w == PODEC_RLS_ASAP ||
                    (rls_w == PODEC_RLS_TARGET && target_reached_i)) begin
                    // (RULE6) Clear new setpoint
                    // (RULE7) Held controlword updated
                    cw_d[PODEC_CW_NEWSP] = 1'b0;
                    shk_d = PODEC_SHK_ACK;
                end else if (rls_w != PODEC_RLS_TARGET) begin
                    shk_d = PODEC_SHK_IDLE;
                end
            end
            PODEC_SHK_ACK: begin
                // (RULE6) Then clear acknowledge
                ack_d = 1'b0;
                shk_d = PODEC_SHK_IDLE;
            end
            default: shk_d = PODEC_SHK_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            cw_q  <= '0;
            ack_q <= 1'b0;
            shk_q <= PODEC_SHK_IDLE;
        end else begin
            cw_q  <= cw_d;
            ack_q <= ack_d;
            shk_q <= shk_d;
        end
    end

    // Target resolution and rotary direction
    logic signed [31:0] base_w;
    logic signed [31:0] tgt_w;
    logic signed [31:0] diff_w;
    logic signed [31:0] span_w;
    logic               inert_w;

    always_comb begin
        inert_w = 1'b0;
        base_w  = '0;
        // (RULE2) Relative bit in controlword
        if (cw_q[PODEC_CW_REL]) begin
            case (rel_w)
                // (RULE3) Previous target, zero at start
                PODEC_REL_PREV:   base_w = prev_tgt_q;
                // (RULE4) Ramp generator output
                PODEC_REL_RAMP:   base_w = move_req_i.ramp_pos;
                // (RULE5) Actual position base
                PODEC_REL_ACTUAL: base_w = move_req_i.actual_pos;
                default:          inert_w = 1'b1;
            endcase
        end
        tgt_w  = base_w + move_req_i.target;
        diff_w = tgt_w - move_req_i.actual_pos;
        span_w = move_req_i.range_max - move_req_i.range_min;
    end

    always_comb begin
        mv_d       = mv_q;
        mv_d.valid = 1'b0;
        prev_tgt_d = prev_tgt_q;
        if (move_req_i.valid && !inert_w) begin
            mv_d.valid        = 1'b1;
            mv_d.via_limit    = 1'b0;
            mv_d.dir_positive = (diff_w >= 0);
            mv_d.target       = tgt_w;
            case (dir_w)
                PODEC_DIR_LINEAR: begin
                    // (RULE10) Wrap at range limits
                    if (span_w != 0 && tgt_w > move_req_i.range_max) begin
                        mv_d.target    = tgt_w - span_w;
                        mv_d.via_limit = 1'b1;
                    end else if (span_w != 0 &&
                                 tgt_w < move_req_i.range_min) begin
                        mv_d.target    = tgt_w + span_w;
                        mv_d.via_limit = 1'b1;
                    end
                end
                PODEC_DIR_NEGATIVE: begin
                    // (RULE11) Negative only, via minimum
                    mv_d.dir_positive = 1'b0;
                    mv_d.via_limit    = (diff_w > 0);
                end
                PODEC_DIR_POSITIVE: begin
                    // (RULE12) Positive only, via maximum
                    mv_d.dir_positive = 1'b1;
                    mv_d.via_limit    = (diff_w < 0);
                end
                PODEC_DIR_SHORTEST: begin
                    // (RULE13) Shortest path, half span test
                    if (diff_w >= 0) begin
                        mv_d.dir_positive = (diff_w < (span_w >>> 1));
                    end else begin
                        mv_d.dir_positive = (-diff_w >= (span_w >>> 1));
                    end
                    mv_d.via_limit = 1'b0;
                end
                default: mv_d.valid = 1'b0;
            endcase
            prev_tgt_d = mv_d.target;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            mv_q       <= '0;
            prev_tgt_q <= '0;
        end else begin
            mv_q       <= mv_d;
            prev_tgt_q <= prev_tgt_d;
        end
    end

    assign obj_rdata_o  = rdata_q;
    assign obj_rvalid_o = rvalid_q;
    assign obj_err_o    = err_q;
    assign cw_o         = cw_q;
    assign sp_ack_o     = ack_q;
    assign move_o       = mv_q;

endmodule

// ### sim/podec_chk_sva.sv
/* Port checker for the positioning option decoder.
   Assumes one clock and a bind onto podec_top. */
`timescale 1ns/1ps
module podec_chk (
    input wire logic                       clk_sys_i,    // Clock
    input wire logic                       rst_n_i,      // Reset, low
    input wire podec_pkg::podec_obj_req_t  obj_req_i,    // Object access
    input wire logic                       obj_rvalid_o, // Read valid
    input wire logic                       obj_err_o,    // Error pulse
    input wire logic                       cw_wr_i,      // Cw write
    input wire logic [15:0]                cw_o,         // Controlword
    input wire logic                       sp_ack_set_i, // Ack set
    input wire logic                       sp_ack_o,     // Ack bit
    input wire podec_pkg::podec_move_req_t move_req_i,   // Move request
    input wire podec_pkg::podec_move_t     move_o        // Resolved move
);
    import podec_pkg::*;
    logic [15:0] opt_q;
    logic [15:0] opt_d;
    logic        mapped;
    logic        in_rng;
    logic        rsvd;
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    // Shadow copy of the option word
    always_comb begin
        opt_d = opt_q;
        if (obj_req_i.wr && obj_req_i.index == PODEC_IDX_OPTIONS)
            opt_d = obj_req_i.wdata[15:0];
    end
    always_ff @(posedge clk_sys_i) begin
        opt_q <= rst_n_i ? opt_d : PODEC_OPT_RESET;
    end
    assign mapped = obj_req_i.index inside {PODEC_IDX_OPTIONS,
                    PODEC_IDX_FOLLOW, PODEC_IDX_INPUTS};
    assign in_rng = move_req_i.target >= move_req_i.range_min &&
                    move_req_i.target <= move_req_i.range_max;
    assign rsvd = cw_o[6] && opt_q[1:0] == 2'b11;
    property p_rd; obj_req_i.rd && mapped |=> obj_rvalid_o; endproperty
    a_rd: assert property (p_rd)
        else $error("read of mapped index not answered");
    property p_err; (obj_req_i.wr && obj_req_i.index != PODEC_IDX_OPTIONS)
        || (obj_req_i.rd && !mapped) |=> obj_err_o; endproperty
    a_err: assert property (p_err)
        else $error("refused access gave no error");
    property p_asap; sp_ack_set_i && !sp_ack_o && opt_q[5:4] == 2'b10
        |-> ##2 !cw_o[4]; endproperty
    a_asap: assert property (p_asap)
        else $error("new setpoint not released at once");
    property p_ack_clr; $fell(cw_o[4]) && !$past(cw_wr_i)
        && opt_q[5:4] != 2'b00 |=> !sp_ack_o; endproperty
    a_ack_clr: assert property (p_ack_clr)
        else $error("acknowledge not cleared after release");
    property p_mv; move_req_i.valid && !rsvd |=> move_o.valid; endproperty
    a_mv: assert property (p_mv)
        else $error("move not resolved");
    property p_mv_rsvd; move_req_i.valid && rsvd |=> !move_o.valid;
    endproperty
    a_mv_rsvd: assert property (p_mv_rsvd)
        else $error("reserved relative code started a move");
    property p_abs; move_req_i.valid && !cw_o[6] && in_rng
        |=> move_o.target == $past(move_req_i.target); endproperty
    a_abs: assert property (p_abs)
        else $error("absolute target altered");
    property p_neg; move_req_i.valid && !rsvd && opt_q[7:6] == 2'b01
        |=> !move_o.dir_positive; endproperty
    a_neg: assert property (p_neg)
        else $error("negative-only policy moved positive");
endmodule
bind podec_top podec_chk u_chk (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .obj_req_i(obj_req_i),
    .obj_rvalid_o(obj_rvalid_o), .obj_err_o(obj_err_o), .cw_wr_i(cw_wr_i),
    .cw_o(cw_o), .sp_ack_set_i(sp_ack_set_i), .sp_ack_o(sp_ack_o),
    .move_req_i(move_req_i), .move_o(move_o));

// ### sim/podec_host.sv
/* Fieldbus host model: object accesses and controlword writes.
   Assumes the decoder answers on the taking edge, seen at the next negedge. */
`timescale 1ns/1ps
module podec_host (
    input  wire logic                clk_sys_i,    // Clock
    output podec_pkg::podec_obj_req_t obj_req_o,   // Object access
    input  wire logic [31:0]         obj_rdata_i,  // Read data
    input  wire logic                obj_rvalid_i, // Read valid
    input  wire logic                obj_err_i,    // Error pulse
    output logic                     cw_wr_o,      // Cw write
    output logic [15:0]              cw_wdata_o    // Cw value
);
    import podec_pkg::*;
    initial begin
        obj_req_o = '0;
        cw_wr_o = 1'b0;
        cw_wdata_o = 16'h0000;
    end
    // Returns {err, rvalid} and the read data
    task automatic access(input logic w, input logic [15:0] idx,
        input logic [31:0] wd, output logic [1:0] st, output logic [31:0] rd);
        @(negedge clk_sys_i);
        obj_req_o = '{w, !w, idx, wd};
        @(negedge clk_sys_i);
        obj_req_o = '{1'b0, 1'b0, ~idx, ~wd};
        st = {obj_err_i, obj_rvalid_i};
        rd = obj_rdata_i;
    endtask
    task automatic cw_write(input logic [15:0] v);
        @(negedge clk_sys_i);
        cw_wr_o = 1'b1;
        cw_wdata_o = v;
        @(negedge clk_sys_i);
        cw_wr_o = 1'b0;
        cw_wdata_o = ~v;
    endtask
endmodule

// ### sim/test_positioning_option_decoder.sv
/* Self-checking bench for the positioning option decoder.
   Assumes the host model in podec_host and a 250 MHz clock. */
`timescale 1ns/1ps
module test_positioning_option_decoder;
    import podec_pkg::*;
    logic clk_sys_i = 1'b0, rst_n_i = 1'b0, sp_ack_set_i = 1'b0;
    logic target_reached_i = 1'b0, cw_wr_i, obj_rvalid_o, obj_err_o;
    logic sp_ack_o;
    logic lower_sw = 1'b1, upper_sw = 1'b0, ref_sw = 1'b1;
    logic [7:0] gp_in = 8'ha5;
    logic [15:0] cw_wdata_i, cw_o;
    logic [31:0] obj_rdata_o;
    podec_obj_req_t obj_req_i;
    podec_move_req_t move_req_i = '0;
    podec_move_t move_o;
    logic signed [31:0] follow_err_i = -32'sd5;
    int checks = 0, n_mismatch = 0;
    always #2 clk_sys_i = ~clk_sys_i;
    podec_top dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
        .obj_req_i(obj_req_i), .obj_rdata_o(obj_rdata_o),
        .obj_rvalid_o(obj_rvalid_o), .obj_err_o(obj_err_o),
        .cw_wr_i(cw_wr_i), .cw_wdata_i(cw_wdata_i), .cw_o(cw_o),
        .sp_ack_set_i(sp_ack_set_i), .sp_ack_o(sp_ack_o),
        .target_reached_i(target_reached_i), .move_req_i(move_req_i),
        .move_o(move_o), .follow_err_i(follow_err_i),
        .lower_travel_switch_i(lower_sw), .upper_travel_switch_i(upper_sw),
        .reference_switch_i(ref_sw), .gp_in_i(gp_in));
    podec_host host (.clk_sys_i(clk_sys_i), .obj_req_o(obj_req_i),
        .obj_rdata_i(obj_rdata_o), .obj_rvalid_i(obj_rvalid_o),
        .obj_err_i(obj_err_o), .cw_wr_o(cw_wr_i), .cw_wdata_o(cw_wdata_i));
    task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic mv(input logic signed [31:0] t, r, a, mn, mx);
        @(negedge clk_sys_i);
        move_req_i = '{1'b1, t, r, a, mn, mx};
        @(negedge clk_sys_i);
        move_req_i = ~move_req_i;
    endtask
    task automatic t_regs();
        logic [1:0] s;
        logic [31:0] d;
        host.access(1'b0, PODEC_IDX_OPTIONS, 32'h0, s, d);
        chk({s, d}, {2'b01, 32'h0000_0001});
        host.access(1'b0, PODEC_IDX_FOLLOW, 32'h0, s, d);
        chk({s, d}, {2'b01, 32'hffff_fffb});
        host.access(1'b0, PODEC_IDX_INPUTS, 32'h0, s, d);
        chk({s, d}, {2'b01, 32'h00a5_0005});
        lower_sw = 1'b0;
        upper_sw = 1'b1;
        ref_sw = 1'b0;
        gp_in = 8'h3c;
        repeat (3) @(negedge clk_sys_i);
        host.access(1'b0, PODEC_IDX_INPUTS, 32'h0, s, d);
        chk({s, d}, {2'b01, 32'h003c_0002});
        host.access(1'b1, PODEC_IDX_FOLLOW, 32'h1, s, d);
        chk({s, 32'h0}, {2'b10, 32'h0});
        host.access(1'b0, 16'h6000, 32'h0, s, d);
        chk({s, d}, {2'b11, 32'h0});
        host.access(1'b1, PODEC_IDX_OPTIONS, 32'h0000_ffff, s, d);
        host.access(1'b0, PODEC_IDX_OPTIONS, 32'h0, s, d);
        chk({s, d}, {2'b01, 32'h0000_ffff});
        $display("register test done");
    endtask
    task automatic t_rel();
        logic [1:0] s;
        logic [31:0] d;
        int e[4] = '{60, 110, 210, 210};
        host.access(1'b1, PODEC_IDX_OPTIONS, 32'h0, s, d);
        host.cw_write(16'h0000);
        mv(50, 100, 200, -1000, 1000);
        chk({1'b1, move_o.valid, move_o.target}, {2'b11, 32'd50});
        host.cw_write(16'h0040);
        for (int c = 0; c < 4; c++) begin
            host.access(1'b1, PODEC_IDX_OPTIONS, c, s, d);
            mv(10, 100, 200, -1000, 1000);
            // Codes 00, 01, 10 and reserved 11
            chk({1'b0, move_o.valid, move_o.target}, {1'b0, c < 3, e[c]});
        end
        $display("relative test done");
    endtask
    task automatic t_dir();
        logic [1:0] s;
        logic [31:0] d;
        int tg[4] = '{1100, 300, 100, 100};
        int ac[4] = '{0, 200, 200, 10};
        int mn[4] = '{-1000, -1000, -1000, 0};
        int mx[4] = '{1000, 1000, 1000, 360};
        int et[4] = '{-900, 300, 100, 100};
        logic ed[4] = '{1'b1, 1'b0, 1'b1, 1'b1};
        host.cw_write(16'h0000);
        for (int c = 0; c < 4; c++) begin
            host.access(1'b1, PODEC_IDX_OPTIONS, c << 6, s, d);
            mv(tg[c], 0, ac[c], mn[c], mx[c]);
            chk({1'b0, move_o.dir_positive, move_o.target}, {1'b0, ed[c], et[c]});
            chk({33'h0, move_o.via_limit}, {33'h0, c < 3});
        end
        $display("direction test done");
    endtask
    task automatic shk_run(input logic [31:0] o);
        logic [1:0] s;
        logic [31:0] d;
        host.access(1'b1, PODEC_IDX_OPTIONS, o, s, d);
        host.cw_write(16'h0010);
        @(negedge clk_sys_i);
        sp_ack_set_i = 1'b1;
        @(negedge clk_sys_i);
        sp_ack_set_i = 1'b0;
        repeat (4) @(negedge clk_sys_i);
    endtask
    task automatic t_shk();
        shk_run(32'h20);
        chk({32'h0, cw_o[4], sp_ack_o}, 34'h0);
        shk_run(32'h10);
        chk({32'h0, cw_o[4], sp_ack_o}, 34'h3);
        target_reached_i = 1'b1;
        repeat (4) @(negedge clk_sys_i);
        chk({32'h0, cw_o[4], sp_ack_o}, 34'h0);
        target_reached_i = 1'b0;
        shk_run(32'h00);
        chk({32'h0, cw_o[4], sp_ack_o}, 34'h3);
        shk_run(32'h30);
        chk({32'h0, cw_o[4], sp_ack_o}, 34'h3);
        $display("handshake test done");
    endtask
    task automatic t_rst();
        logic [1:0] s;
        logic [31:0] d;
        @(negedge clk_sys_i);
        rst_n_i = 1'b0;
        repeat (6) @(negedge clk_sys_i);
        rst_n_i = 1'b1;
        chk({17'h0, cw_o, sp_ack_o}, 34'h0);
        host.access(1'b0, PODEC_IDX_OPTIONS, 32'h0, s, d);
        chk({s, d}, {2'b01, 32'h0000_0001});
        host.access(1'b1, PODEC_IDX_OPTIONS, 32'h0, s, d);
        host.cw_write(16'h0040);
        mv(10, 100, 200, -1000, 1000);
        chk({1'b0, move_o.valid, move_o.target}, {2'b01, 32'h0000_000a});
        $display("reset test done");
    endtask
    initial begin
        #100000;
        n_mismatch++;
        finish_test();
    end
    initial begin
        repeat (6) @(negedge clk_sys_i);
        rst_n_i = 1'b1;
        t_regs();
        t_rel();
        t_dir();
        t_shk();
        t_rst();
        finish_test();
    end
endmodule
